// *** hw/nand_host_pkg.sv ***
/*
  Constants for the NAND status and parameter-page host controller.
  Assumes a 125 MHz system clock and an 8-bit multiplexed flash port.
*/
package nand_host_pkg;
  localparam int unsigned CLK_PS = 8000;
  localparam int unsigned STROBE_PS = 64000;
  localparam int unsigned STROBE_CYC = (STROBE_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned TWB_PS = 100000;
  localparam int unsigned WB_TICKS = (TWB_PS + STROBE_PS - 1) / STROBE_PS;
  localparam int unsigned PWRUP_US = 2000;
  localparam int unsigned PWRUP_CYC = PWRUP_US * 1000000 / CLK_PS;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROW_A = 8'h04;
  localparam logic [7:0] OFS_ROW_B = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_PARAM0 = 8'h10;
  localparam logic [7:0] OFS_PARAM1 = 8'h14;
  localparam logic [7:0] OFS_PARAM2 = 8'h18;
  // control fields
  localparam int unsigned CTRL_POLL = 3;
  localparam int unsigned CTRL_WP_REL = 8;
  localparam int unsigned CTRL_CLR_REF = 9;
  // operation codes in CTRL[2:0]
  localparam logic [2:0] OP_STAT = 3'h1;
  localparam logic [2:0] OP_STAT_PL = 3'h2;
  localparam logic [2:0] OP_PARAM = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  // flash command bytes
  localparam logic [7:0] CMD_STAT = 8'h70;
  localparam logic [7:0] CMD_STAT_PL = 8'h78;
  localparam logic [7:0] CMD_PARAM = 8'hEC;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ = 8'h00;
  // parameter page layout
  localparam logic [9:0] PARAM_BYTES = 10'h300;
  localparam logic [7:0] PB_IL_ADDR = 8'h71;
  localparam logic [7:0] PB_IL_ATTR = 8'h72;
  localparam logic [7:0] PB_TMODE = 8'h81;
  localparam logic [7:0] PB_TPROG = 8'h85;
  localparam logic [7:0] PB_TERASE = 8'h87;
  localparam logic [7:0] PB_TREAD = 8'h89;
  localparam logic [7:0] PB_CRC_END = 8'hFD;
  localparam logic [7:0] PB_CRC_LO = 8'hFE;
  localparam logic [15:0] CRC_INIT = 16'h4F4E;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  // row address layout
  localparam int unsigned PLANE_BIT = 6;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned ROW_W = 24;
  typedef enum logic [7:0] {
    S_PWR = 8'h01, S_IDLE = 8'h02, S_WR_LO = 8'h04, S_WR_HI = 8'h08,
    S_WB = 8'h10, S_RB = 8'h20, S_RD_LO = 8'h40, S_RD_HI = 8'h80
  } seq_state_t;
endpackage

// *** hw/nand_status_host.sv ***
/*
  Host controller that reads NAND status and the parameter page.
  Assumes an AXI4-Lite master, external pull-up on the ready/busy wire,
  and one flash target on the port.
*/
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
//Contract
// R01: page program, erase, read maximum times are little-endian microsecond counts.
// R02: timing-mode field reads 1Fh,00h or 0Fh,00h, mode 0 always set.
// R03: two identical copies of the 256 parameter bytes follow the first.
// R04: each copy ends with a 16-bit check, host recomputes it.
// R05: interleaved address bits and interleave attribute both report zero.
// R06: check covers bytes 0..253 from the standard initial value.
// R07: after 70h each read cycle drives the status byte.
// R08: status byte tracks progress without toggling read strobe.
// R09: status mode persists; reissue 00h before resuming data reads.
// R10: status bit 0 is program or erase fail flag.
// R11: status bit 5 is array ready.
// R12: status bit 6 is ready for a new command.
// R13: status bit 7 low means block protected.
// R14: status bits 1 to 4 read zero.
// R15: 78h plus three row cycles returns addressed plane status.
// R16: no plane status command while reset executes.
// R17: ready/busy low during accepted operation, high when done.
// R18: ready/busy is open-drain, wired-OR with pull-up.
// R19: hold write protect low during power-up and power-down.
// R20: wait at least 2ms after power-up before any command.
// R21: multi-plane addresses differ in plane, match in page, same unit; code compares only the plane bit and page bits.
// R22: multi-plane copy-back stays within one plane.
module nand_status_host import nand_host_pkg::*; #(
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  seq_state_t st_q;
  logic [31:0] pwr_cnt_q;
  logic pwr_done_q, wp_rel_q, refused_q, start_q, poll_q, reset_busy_q;
  logic [2:0] op_q, cmd_op_q;
  logic [ROW_W-1:0] row_a_q, row_b_q;
  logic [7:0] div_q, rd_byte_q, stat_byte_q, cnt_q;
  logic [1:0] addr_left_q, copy_q;
  logic [9:0] rd_left_q;
  logic [7:0] io_s1_q, io_s2_q, pidx_q, crc_lo_q;
  logic rb_s1_q, rb_s2_q, param_ok_q, param_fail_q, addr_ok_q, cpb_ok_q;
  logic [15:0] crc_q, sh_tm, sh_prog, sh_er, sh_rd, tm_q, prog_q, er_q, rdt_q;
  logic [7:0] sh_ila, sh_ilb, ila_q, ilb_q;
  logic tick, rd_take, wr_acc, ctrl_wr;

  // byte-wise CRC, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // strobe-rate enable divider
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) div_q <= 8'h00;
    else div_q <= (div_q == 8'(STROBE_CYC - 1)) ? 8'h00 : div_q + 8'h01;
  end
  assign tick = (div_q == 8'(STROBE_CYC - 1));

  // pin synchronisers; ready/busy is only sensed, never driven
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end
    else
    begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      rb_s1_q <= rb_n; // R18
      rb_s2_q <= rb_s1_q;
    end
  end

  // power-up wait and write-protect hold
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwr_cnt_q <= 32'h0;
      pwr_done_q <= 1'b0;
      wp_n <= 1'b0;
    end
    else
    begin
      if (!pwr_done_q) pwr_cnt_q <= pwr_cnt_q + 32'h1;
      if (pwr_cnt_q == PWRUP_CYCLES - 1) pwr_done_q <= 1'b1; // R20
      wp_n <= pwr_done_q & wp_rel_q; // R19
    end
  end

  // AXI4-Lite slave: address and data taken together
  assign wr_acc = s_awready & s_awvalid & s_wvalid;
  assign ctrl_wr = wr_acc & (s_awaddr == OFS_CTRL) & s_wstrb[0];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rresp <= 2'h0;
      s_rdata <= 32'h0;
    end
    else
    begin
      s_awready <= s_awvalid & s_wvalid & !s_awready & !s_bvalid;
      s_wready <= s_awvalid & s_wvalid & !s_awready & !s_bvalid;
      if (wr_acc)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= (s_awaddr <= OFS_PARAM2 && s_awaddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      else if (s_bready) s_bvalid <= 1'b0;
      s_arready <= s_arvalid & !s_arready & !s_rvalid;
      if (s_arready & s_arvalid)
      begin
        s_rvalid <= 1'b1;
        s_rresp <= 2'h0;
        case (s_araddr)
          OFS_CTRL: s_rdata <= {22'h0, refused_q, wp_rel_q, 4'h0, poll_q, op_q};
          OFS_ROW_A: s_rdata <= {8'h0, row_a_q};
          OFS_ROW_B: s_rdata <= {8'h0, row_b_q};
          OFS_STAT: s_rdata <= {14'h0, copy_q, stat_byte_q, cpb_ok_q, addr_ok_q,
            param_fail_q, param_ok_q, rb_s2_q, refused_q, pwr_done_q, st_q != S_IDLE};
          OFS_PARAM0: s_rdata <= {tm_q, ilb_q, ila_q};
          OFS_PARAM1: s_rdata <= {er_q, prog_q};
          OFS_PARAM2: s_rdata <= {16'h0, rdt_q};
          default:
          begin
            s_rdata <= 32'h0;
            s_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_rready) s_rvalid <= 1'b0;
    end
  end

  // control registers, start pulse and refusal flag (set wins)
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_q <= 3'h0;
      poll_q <= 1'b0;
      wp_rel_q <= 1'b0;
      refused_q <= 1'b0;
      start_q <= 1'b0;
      row_a_q <= '0;
      row_b_q <= '0;
    end
    else
    begin
      start_q <= 1'b0;
      if (ctrl_wr)
      begin
        op_q <= s_wdata[2:0];
        poll_q <= s_wdata[CTRL_POLL];
        if (s_wstrb[1]) wp_rel_q <= s_wdata[CTRL_WP_REL];
        if (s_wstrb[1] && s_wdata[CTRL_CLR_REF]) refused_q <= 1'b0;
        if (s_wdata[2:0] != 3'h0)
        begin
          if (st_q != S_IDLE || (s_wdata[2:0] == OP_STAT_PL && reset_busy_q)) // R16
            refused_q <= 1'b1;
          else start_q <= 1'b1;
        end
      end
      if (wr_acc && s_awaddr == OFS_ROW_A) row_a_q <= s_wdata[ROW_W-1:0];
      if (wr_acc && s_awaddr == OFS_ROW_B) row_b_q <= s_wdata[ROW_W-1:0];
    end
  end

  // multi-plane address pair checks
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_ok_q <= 1'b0;
      cpb_ok_q <= 1'b1; // reset rows share a plane
    end
    else
    begin
      addr_ok_q <= (row_a_q[PLANE_BIT] != row_b_q[PLANE_BIT]) &&
        (row_a_q[PAGE_W-1:0] == row_b_q[PAGE_W-1:0]); // R21
      cpb_ok_q <= (row_a_q[PLANE_BIT] == row_b_q[PLANE_BIT]); // R22
    end
  end

  // flash port sequencer
  assign rd_take = tick & (st_q == S_RD_LO) & (!poll_q | io_s2_q[6] | cmd_op_q != OP_STAT);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= S_PWR;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      cmd_op_q <= 3'h0;
      addr_left_q <= 2'h0;
      rd_left_q <= 10'h0;
      cnt_q <= 8'h00;
      reset_busy_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_PWR: if (pwr_done_q) st_q <= S_IDLE; // R20
        S_IDLE:
          if (start_q)
          begin
            cmd_op_q <= op_q;
            ce_n <= 1'b0;
            cle <= 1'b1;
            io_oe <= 1'b1;
            we_n <= 1'b0;
            st_q <= S_WR_LO;
            reset_busy_q <= (op_q == OP_RESET);
            addr_left_q <= (op_q == OP_STAT_PL) ? 2'h3 : (op_q == OP_PARAM) ? 2'h1 : 2'h0; // R15
            rd_left_q <= (op_q == OP_PARAM) ? PARAM_BYTES : // R03
              (op_q == OP_STAT || op_q == OP_STAT_PL) ? 10'h1 : 10'h0; // R07
            case (op_q)
              OP_STAT: io_out <= CMD_STAT;
              OP_STAT_PL: io_out <= CMD_STAT_PL;
              OP_PARAM: io_out <= CMD_PARAM;
              OP_RESET: io_out <= CMD_RESET;
              default: io_out <= CMD_READ; // R09
            endcase
          end
        S_WR_LO:
          if (tick)
          begin
            we_n <= 1'b1;
            st_q <= S_WR_HI;
          end
        S_WR_HI:
          if (tick)
          begin
            cle <= 1'b0;
            cnt_q <= 8'h00;
            if (addr_left_q != 2'h0)
            begin
              ale <= 1'b1;
              we_n <= 1'b0;
              addr_left_q <= addr_left_q - 2'h1;
              st_q <= S_WR_LO;
              case (addr_left_q)
                2'h3: io_out <= row_a_q[7:0];
                2'h2: io_out <= row_a_q[15:8];
                2'h1: io_out <= (cmd_op_q == OP_PARAM) ? 8'h00 : row_a_q[23:16];
                default: io_out <= 8'h00;
              endcase
            end
            else
            begin
              ale <= 1'b0;
              io_oe <= 1'b0;
              if (cmd_op_q == OP_PARAM || cmd_op_q == OP_RESET) st_q <= S_WB;
              else if (rd_left_q != 10'h0)
              begin
                read_strobe_n <= 1'b0;
                st_q <= S_RD_LO;
              end
              else
              begin
                ce_n <= 1'b1;
                st_q <= S_IDLE;
              end
            end
          end
        S_WB:
          if (tick)
          begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(WB_TICKS - 1)) st_q <= S_RB;
          end
        S_RB:
          if (tick && rb_s2_q) // R17
          begin
            reset_busy_q <= 1'b0;
            if (rd_left_q != 10'h0)
            begin
              read_strobe_n <= 1'b0;
              st_q <= S_RD_LO;
            end
            else
            begin
              ce_n <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        S_RD_LO:
          if (rd_take) // R08
          begin
            read_strobe_n <= 1'b1;
            rd_left_q <= rd_left_q - 10'h1;
            st_q <= S_RD_HI;
          end
        S_RD_HI:
          if (tick)
          begin
            if (rd_left_q == 10'h0 || (cmd_op_q == OP_PARAM && param_ok_q))
            begin
              ce_n <= 1'b1;
              st_q <= S_IDLE;
            end
            else
            begin
              read_strobe_n <= 1'b0;
              st_q <= S_RD_LO;
            end
          end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // status byte capture; unused bits forced to zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) stat_byte_q <= 8'h00;
    else if (rd_take && cmd_op_q != OP_PARAM)
      stat_byte_q <= {io_s2_q[7:5], 4'h0, io_s2_q[0]}; // R10 R11 R12 R13 R14
  end

  // parameter page walk: shadow per copy, commit first copy whose check holds
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pidx_q <= 8'h00;
      copy_q <= 2'h0;
      crc_q <= CRC_INIT;
      crc_lo_q <= 8'h00;
      param_ok_q <= 1'b0;
      param_fail_q <= 1'b0;
      {sh_tm, sh_prog, sh_er, sh_rd, sh_ila, sh_ilb} <= '0;
      {tm_q, prog_q, er_q, rdt_q, ila_q, ilb_q} <= '0;
    end
    else if (start_q && op_q == OP_PARAM)
    begin
      pidx_q <= 8'h00;
      copy_q <= 2'h0;
      crc_q <= CRC_INIT; // R06
      param_ok_q <= 1'b0;
      param_fail_q <= 1'b0;
    end
    else if (rd_take && cmd_op_q == OP_PARAM)
    begin
      pidx_q <= pidx_q + 8'h01;
      if (pidx_q <= PB_CRC_END) crc_q <= crc_step(crc_q, io_s2_q); // R06
      case (pidx_q)
        PB_IL_ADDR: sh_ila <= io_s2_q; // R05
        PB_IL_ATTR: sh_ilb <= io_s2_q; // R05
        PB_TMODE: sh_tm[7:0] <= io_s2_q; // R02
        PB_TMODE + 8'h01: sh_tm[15:8] <= io_s2_q;
        PB_TPROG: sh_prog[7:0] <= io_s2_q; // R01
        PB_TPROG + 8'h01: sh_prog[15:8] <= io_s2_q;
        PB_TERASE: sh_er[7:0] <= io_s2_q;
        PB_TERASE + 8'h01: sh_er[15:8] <= io_s2_q;
        PB_TREAD: sh_rd[7:0] <= io_s2_q;
        PB_TREAD + 8'h01: sh_rd[15:8] <= io_s2_q;
        PB_CRC_LO: crc_lo_q <= io_s2_q;
        8'hFF:
        begin
          crc_q <= CRC_INIT;
          copy_q <= copy_q + 2'h1; // R03
          if ({io_s2_q, crc_lo_q} == crc_q && !param_ok_q) // R04
          begin
            param_ok_q <= 1'b1;
            {tm_q, prog_q, er_q, rdt_q, ila_q, ilb_q} <=
              {sh_tm, sh_prog, sh_er, sh_rd, sh_ila, sh_ilb};
          end
          else if (copy_q == 2'h2) param_fail_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // checks
  sequence s_cmd_latch;
    cle && !we_n && io_oe && !ce_n;
  endsequence
  a_wp_hold: assert property (@(posedge clk) disable iff (!rstn) !pwr_done_q |=> !wp_n) // R19
    else $error("write protect released during power-up");
  a_no_early_cmd: assert property (@(posedge clk) disable iff (!rstn)
    !pwr_done_q |-> ce_n && we_n) // R20
    else $error("flash strobed before power-up wait");
  a_pwr_count: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pwr_done_q) |-> $past(pwr_cnt_q) == PWRUP_CYCLES - 1) // R20
    else $error("power-up wait length wrong");
  a_stat_mask: assert property (@(posedge clk) disable iff (!rstn)
    $past(rd_take) && cmd_op_q != OP_PARAM |-> stat_byte_q[4:1] == 4'h0 &&
    stat_byte_q[7] == $past(io_s2_q[7])) // R14
    else $error("status byte captured wrongly");
  a_no_contention: assert property (@(posedge clk) disable iff (!rstn)
    io_oe |-> read_strobe_n) // R07
    else $error("port driven while read strobe low");
  a_refuse_plane: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_wr && s_wdata[2:0] == OP_STAT_PL && reset_busy_q |=> refused_q && !start_q) // R16
    else $error("plane status issued during reset");
  a_plane_pair: assert property (@(posedge clk) disable iff (!rstn)
    ##1 addr_ok_q == ($past(row_a_q[PLANE_BIT]) != $past(row_b_q[PLANE_BIT]) &&
    $past(row_a_q[PAGE_W-1:0]) == $past(row_b_q[PAGE_W-1:0]))) // R21
    else $error("multi-plane address check wrong");
  a_copy_plane: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cpb_ok_q == ($past(row_a_q[PLANE_BIT]) == $past(row_b_q[PLANE_BIT]))) // R22
    else $error("copy-back plane check wrong");
  a_crc_commit: assert property (@(posedge clk) disable iff (!rstn)
    $rose(param_ok_q) |-> $past(pidx_q) == 8'hFF) // R04
    else $error("parameter copy accepted off its check bytes");
  a_cmd_start: assert property (@(posedge clk) disable iff (!rstn)
    start_q |=> s_cmd_latch ##STROBE_CYC we_n) // R15
    else $error("command cycle malformed");
  a_busy_wait: assert property (@(posedge clk) disable iff (!rstn)
    st_q == S_RB && !rb_s2_q |=> st_q == S_RB) // R17
    else $error("left busy wait while flash busy");
endmodule // nand_status_host

// *** verif/nand_flash_model.sv ***
/*
  Behavioural flash target: command and address latch, status byte and a
  three-copy parameter page. Assumes the bench resolves io_in and rb_n.
*/
`timescale 1ns/1ps
module nand_flash_model (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic [1:0] fail_plane,
  input wire logic [1:0] bad_copies,
  input wire logic [15:0] busy_len,
  input wire logic kick,
  output logic [7:0] dev_io,
  output logic rb_low,
  output logic [7:0] last_cmd,
  output int cmd_count
);
  logic [7:0] page [0:767];
  logic [7:0] last_q, val;
  logic stat_mode, plane_sel, param_mode, drive, ready;
  logic [23:0] row;
  int cyc, cmd_end, kick_end, rd_cnt, ptr0, idx;
  // check value over bytes 0..253, msb first
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = 16'h4F4E;
    for (int i = 0; i < 254; i++)
      for (int j = 7; j >= 0; j--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ page[i][j]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  // page image; interleave bytes 113 and 114 stay zero
  initial
  begin
    logic [15:0] c;
    for (int i = 0; i < 256; i++)
      page[i] = 8'h00;
    page[129] = 8'h1F;
    page[133] = 8'hE8;
    page[134] = 8'h03;
    page[135] = 8'h10;
    page[136] = 8'h27;
    page[137] = 8'h1E;
    c = crc16();
    page[254] = c[7:0];
    page[255] = c[15:8];
    for (int i = 256; i < 768; i++)
      page[i] = page[i % 256];
    {cyc, cmd_end, kick_end, rd_cnt, ptr0, cmd_count} = '0;
    {stat_mode, plane_sel, param_mode, row, last_q, last_cmd} = '0;
  end
  // command and address bytes land on the write strobe rise
  always @(posedge we_n)
  begin
    if (!ce_n && cle)
    begin
      last_cmd <= io_out;
      cmd_count <= cmd_count + 1;
      stat_mode <= (io_out == 8'h70 || io_out == 8'h78);
      plane_sel <= (io_out == 8'h78);
      param_mode <= 1'b0;
      if (io_out == 8'hFF)
        cmd_end <= cyc + busy_len;
    end
    else if (!ce_n && ale)
    begin
      row <= {io_out, row[23:8]};
      if (last_cmd == 8'hEC)
      begin
        param_mode <= 1'b1;
        ptr0 <= rd_cnt;
        cmd_end <= cyc + busy_len;
      end
    end
  end
  // read strobe rise moves the page pointer
  always @(posedge read_strobe_n)
    if (!ce_n)
      rd_cnt <= rd_cnt + 1;
  // time base and last driven byte
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (kick)
      kick_end <= cyc + busy_len;
    if (drive)
      last_q <= dev_io;
  end
  // status follows progress live; released lines show the inverse
  always_comb
  begin
    ready = (cyc >= cmd_end) && (cyc >= kick_end);
    idx = rd_cnt - ptr0;
    val = {wp_n, ready, ready, 4'h0, plane_sel ? fail_plane[row[6]] : |fail_plane};
    if (param_mode)
      val = (idx < 768) ? page[idx] ^ {7'h00, idx % 256 == 5 && idx / 256 < bad_copies} : 8'h00;
    drive = !ce_n && !read_strobe_n && (stat_mode || (param_mode && ready));
    dev_io = drive ? val : ~last_q;
    rb_low = !ready;
  end
endmodule // nand_flash_model

// *** verif/testbench.sv ***
/*
  Self-checking bench for the flash status host with AXI4-Lite tasks.
  Assumes a short power-up count and the flash target model.
*/
`timescale 1ns/1ps
module testbench import nand_host_pkg::*;;
  localparam logic [31:0] WPR = 32'h1 << CTRL_WP_REL;
  logic clk, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, kick;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, io_oe, rb_n, rb_low;
  logic ce_n, cle, ale, we_n, read_strobe_n, wp_n;
  logic [7:0] s_awaddr, s_araddr, io_out, io_in, dev_io, last_cmd;
  logic [31:0] s_wdata, s_rdata, rd, seed;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, resp, fail_plane, bad_copies;
  logic [15:0] busy_len;
  int cmd_count, num_errors, check_count;
  // wire resolution: host drive, else target; pull-up on ready/busy
  assign io_in = io_oe ? io_out : dev_io;
  assign rb_n = !rb_low;
  nand_status_host #(.PWRUP_CYCLES(20)) nand_status_host_i (.clk(clk), .rstn(rstn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .rb_n(rb_n));
  nand_flash_model nand_flash_model_i (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
    .fail_plane(fail_plane), .bad_copies(bad_copies), .busy_len(busy_len), .kick(kick),
    .dev_io(dev_io), .rb_low(rb_low), .last_cmd(last_cmd), .cmd_count(cmd_count));
  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_stat(input logic wp, input logic rdy, input logic f);
    return {wp, rdy, rdy, 4'h0, f};
  endfunction
  function automatic logic [1:0] exp_pair(input logic [23:0] a, input logic [23:0] b);
    return {a[6] == b[6], a[6] != b[6] && a[5:0] == b[5:0]};
  endfunction
  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    {aw_ok, w_ok} = 2'h0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (s_awvalid && s_awready)
        aw_ok = 1'b1;
      if (s_wvalid && s_wready)
        w_ok = 1'b1;
      s_awvalid <= !aw_ok;
      s_wvalid <= !w_ok;
    end
    s_bready <= 1'b1;
    do @(posedge clk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask
  // start an operation and poll until the controller is idle
  task automatic run_op(input logic [31:0] ctrl);
    axi_wr(OFS_CTRL, ctrl);
    do axi_rd(OFS_STAT); while (rd[0] !== 1'b0);
  endtask
  // watchdog
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    logic [31:0] r, r2;
    logic [23:0] a, b;
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, kick} = '0;
    {s_awaddr, s_araddr, s_wdata, fail_plane, bad_copies} = '0;
    {num_errors, check_count} = '0;
    s_wstrb = 4'hF;
    busy_len = 16'h0028;
    seed = 32'h31;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    axi_wr(OFS_CTRL, {29'h0, OP_STAT});
    axi_rd(OFS_STAT);
    check(rd[2], 1'b1);
    check(cmd_count, 0);
    check(wp_n, 1'b0);
    do axi_rd(OFS_STAT); while (rd[1] !== 1'b1);
    check(wp_n, 1'b0);
    axi_wr(OFS_CTRL, WPR | (32'h1 << CTRL_CLR_REF));
    @(posedge clk); // wp_n follows the register a cycle later
    check(wp_n, 1'b1);
    // plain and plane-selective status with random fail flags and rows
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      fail_plane <= r[1:0];
      axi_wr(OFS_ROW_A, {8'h00, r[31:8]});
      run_op((r[2] ? WPR : 32'h0) | (r[3] ? OP_STAT_PL : OP_STAT));
      check(rd[15:8], exp_stat(r[2], 1'b1, r[3] ? (r[14] ? r[1] : r[0]) : |r[1:0]));
      check(last_cmd, r[3] ? CMD_STAT_PL : CMD_STAT);
    end
    // array busy: single sample shows busy, polling waits for ready
    fail_plane <= 2'h0;
    busy_len <= 16'h012C;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    run_op(WPR | OP_STAT);
    check(rd[15:8], exp_stat(1'b1, 1'b0, 1'b0));
    run_op(WPR | (32'h1 << CTRL_POLL) | OP_STAT);
    check(rd[15:8], exp_stat(1'b1, 1'b1, 1'b0));
    // parameter page with 0..3 corrupted leading copies
    busy_len <= 16'h0028;
    for (int k = 0; k < 4; k++)
    begin
      bad_copies <= k[1:0];
      run_op(WPR | OP_PARAM);
      check(rd[5:4], k == 3 ? 2'h2 : 2'h1);
      check(rd[17:16], k == 3 ? 2'h3 : 2'(k + 1));
      axi_rd(OFS_PARAM0);
      if (k < 3)
        check(rd, 32'h001F_0000);
      axi_rd(OFS_PARAM1);
      if (k < 3)
        check(rd, 32'h2710_03E8);
      axi_rd(OFS_PARAM2);
      if (k < 3)
        check(rd, 32'h0000_001E);
    end
    // plane status during a reset is refused
    axi_wr(OFS_CTRL, WPR | OP_RESET);
    axi_wr(OFS_CTRL, WPR | OP_STAT_PL);
    axi_rd(OFS_STAT);
    check(rd[2], 1'b1);
    do axi_rd(OFS_STAT); while (rd[0] !== 1'b0);
    check(last_cmd, CMD_RESET);
    run_op(WPR | (32'h1 << CTRL_CLR_REF) | OP_RESUME);
    check(last_cmd, CMD_READ);
    // multi-plane address pairs: plane-flipped, identical and random rows in turn
    for (int i = 0; i < 15; i++)
    begin
      r = rnd();
      r2 = rnd();
      a = r[23:0];
      b = (i % 3 == 0) ? a ^ 24'h00_0040 : (i % 3 == 1) ? a : r2[23:0];
      axi_wr(OFS_ROW_A, {8'h00, a});
      axi_wr(OFS_ROW_B, {8'h00, b});
      axi_rd(OFS_STAT);
      check(rd[7:6], exp_pair(a, b));
      axi_rd(OFS_ROW_B);
      check(rd, {8'h00, b});
    end
    // unmapped place answers with an error and zero data
    axi_wr(8'h40, 32'h0);
    check(resp, 2'h2);
    axi_rd(8'h40);
    check(resp, 2'h2);
    check(rd, 32'h0);
    wrap_up();
  end
endmodule // testbench
